/* File: rtl/otp_crc_pkg.sv */
// Purpose: Shared constants and types for the OTP lock, identifier and CRC checking block.
// Assumes: Byte-wide register map reached over a plain strobe port.
// Notes:   Register offsets, lock and status field positions, the CRC seed, the reset byte and the walker counts live here.
package otp_crc_pkg;
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 8;
  localparam int          CRC_W            = 4;
  localparam logic [3:0]  CRC_POLY         = 4'h9;
  localparam logic [3:0]  CRC_SEED         = 4'h0;
  localparam int          LOCK_POS         = 7;
  localparam int          ID_MSB           = 6;
  localparam int          ID_LSB           = 4;
  localparam int          CRC_MSB          = 3;
  localparam logic [7:0]  CTRL_OFS         = 8'h30;
  localparam logic [7:0]  BURN_OFS         = 8'h31;
  localparam logic [7:0]  STAT_OFS         = 8'h32;
  localparam logic [7:0]  RW_BASE          = 8'h40;
  localparam logic [7:0]  DEV_LOCK_OFS     = 8'h4F;
  localparam logic [7:0]  MOD_BASE         = 8'h50;
  localparam logic [7:0]  MOD_LOCK_OFS     = 8'h5F;
  localparam logic [7:0]  BLK_A_LOCK_OFS   = 8'hAF;
  localparam logic [7:0]  BLK_B_LOCK_OFS   = 8'hBF;
  localparam logic [7:0]  BLK_C_LOCK_OFS   = 8'hCF;
  localparam logic [7:0]  BLK_D_LOCK_OFS   = 8'hDF;
  localparam logic [7:0]  BLK_E_LOCK_OFS   = 8'hEF;
  localparam logic [7:0]  BLK_F_LOCK_OFS   = 8'hFF;
  localparam logic [2:0]  RW_PAGE_HI       = 3'h2;
  localparam logic [3:0]  LOCK_LOW_NIBBLE  = 4'hF;
  localparam logic [3:0]  FACTORY_FIRST_HI = 4'hA;
  localparam logic [3:0]  USER_FIRST_HI    = 4'hE;
  localparam logic [3:0]  BLOCK_HI_OFFSET  = 4'h9;
  localparam logic [5:0]  BLOCK_DATA_BYTES = 6'h0F;
  localparam logic [5:0]  ARRAY_BYTES      = 6'h20;
  localparam logic [2:0]  NUM_BLOCKS       = 3'h7;
  localparam logic [7:0]  RESET_BYTE       = 8'h00;
  localparam int          INIT_POS         = 0;
  localparam int          BUSY_POS         = 0;
  localparam int          OTP_ERR_POS      = 1;
  localparam int          ARR_ERR_POS      = 2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  // Block 0 is the modifiable region, blocks 1 to 6 are the pages 0xA0 to 0xF0.
  function automatic logic [7:0] block_base(input logic [2:0] idx);
    block_base = (idx == 3'h0) ? MOD_BASE : {4'(idx) + BLOCK_HI_OFFSET, 4'h0};
  endfunction : block_base
endpackage : otp_crc_pkg

/* File: rtl/crc4_byte_step.sv */
// Purpose: One byte of a 4-bit CRC, most significant bit first.
// Assumes: Caller holds the running remainder.
// Notes:   Purely combinational.
module crc4_byte_step #(
  parameter logic [3:0] POLY = otp_crc_pkg::CRC_POLY
) (
  input  wire logic [3:0] crc_in,
  input  wire logic [7:0] data_in,
  output logic      [3:0] crc_out
);
  always_comb begin
    logic [3:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      if (c[3] ^ data_in[i]) begin
        c = {c[2:0], 1'b0} ^ POLY;
      end else begin
        c = {c[2:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule : crc4_byte_step

/* File: rtl/crc_byte_walker.sv */
// Purpose: Walks a run of byte addresses upward and folds each byte, except skip_addr when skip_en is set, into a 4-bit CRC.
// Assumes: Read data for rd_addr is returned combinationally in the same cycle.
// Notes:   One byte per clock; done pulses one cycle after the last byte.
module crc_byte_walker #(
  parameter int CNT_W = 6
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             start,
  input  wire logic [7:0]       base,
  input  wire logic [CNT_W-1:0] count,
  input  wire logic             skip_en,
  input  wire logic [7:0]       skip_addr,
  input  wire logic [7:0]       rd_data,
  output logic      [7:0]       rd_addr,
  output logic                  busy,
  output logic                  done,
  output logic      [3:0]       crc
);
  logic [7:0]       addr_q;
  logic [CNT_W-1:0] left_q;
  logic             busy_q;
  logic             done_q;
  logic [3:0]       crc_q;
  logic [3:0]       crc_step;

  crc4_byte_step u_step (
    .crc_in  (crc_q),
    .data_in (rd_data),
    .crc_out (crc_step)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      addr_q <= 8'h00;
      left_q <= '0;
      crc_q  <= otp_crc_pkg::CRC_SEED;
    end else if (!busy_q && start) begin
      busy_q <= 1'b1;
      addr_q <= base;
      left_q <= count;
      crc_q  <= otp_crc_pkg::CRC_SEED;
    end else if (busy_q) begin
      // Ascending addresses, one whole byte per step.
      if (!(skip_en && addr_q == skip_addr)) begin
        crc_q <= crc_step;
      end
      addr_q <= addr_q + 8'h01;
      left_q <= left_q - CNT_W'(1);
      if (left_q == CNT_W'(1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && (left_q == CNT_W'(1));
    end
  end

  assign rd_addr = addr_q;
  assign busy    = busy_q;
  assign done    = done_q;
  assign crc     = crc_q;

  AST_WALK_SEEDED: assert property (@(posedge clk) disable iff (srst)
    (start && !busy_q) |=> (crc_q == 4'h0 && addr_q == $past(base)))
    else $error("walker did not seed the CRC or load the base");
  AST_WALK_BOUNDED: assert property (@(posedge clk) disable iff (srst)
    (start && !busy_q) |-> ##[2:64] done_q)
    else $error("walker did not finish in time");
endmodule : crc_byte_walker

/* File: rtl/otp_block_lock_crc_check.sv */
// Purpose: Lock, identifier and CRC handling of the OTP blocks and the mirror register array.
// Assumes: Host strobes are one cycle, synchronous to CORE_CLK, never both at once.
// Notes:   Reset clears the array, standing for unprogrammed OTP after power-on.
// Notes on behaviour
// - Burning a block also writes its lock bit, identifier and CRC byte itself.
// - Bit 7 of a lock byte is 0 before burning and 1 after.
// - Bits 6 to 4 hold identifier 0 for modifiable region, 1 to 6 for A-F.
// - Bits 3 to 0 hold block CRC; unburned mod, E and F bytes read zero.
// - CRC polynomial x^4+x^3+1, remainder seeded to zero.
// - Each byte enters MSB first, bytes in ascending address order.
// - Factory and user blocks are each checked by a 4-bit CRC over the block.
// - Modifiable region OTP copy is checked against its own lock byte CRC.
// - Before init completes, host writes to the mirror registers are accepted.
// - After init completes, a running CRC covers writable and modifiable registers, skipping the device lock byte 0x4F.
// - Reading reserved locations answers validly; reserved bits read zero here.
// - Writing reserved locations is carried out and answered validly.
// - Reading an unmapped address answers validly with 0x00.
// - Writing an unmapped address changes nothing and answers 0x00.
// - Writing a read-only register keeps it and answers its present contents.
// - User data bytes take part in the user block CRC check.
//
// Design decision made here: the plain strobed port.
module otp_block_lock_crc_check (
  input  wire logic                    CORE_CLK,
  input  wire logic                    SRST,
  input  wire otp_crc_pkg::bus_req_t   BUS_REQ,
  output logic      [7:0]              BUS_RDATA,
  output logic                         BUS_RESP_VALID,
  output logic                         INIT_COMPLETE,
  output logic                         BURN_BUSY,
  output logic                         OTP_CRC_ERR,
  output logic                         ARRAY_CRC_ERR
);
  typedef enum logic [1:0] {ST_IDLE, ST_BURN, ST_CHECK} walk_state_t;

  logic [7:0]  mem_q [256];
  logic [7:0]  mod_otp_q [16];
  walk_state_t state_q;
  logic        init_q;
  logic        otp_err_q;
  logic        arr_err_q;
  logic        burn_pend_q;
  logic        burn_busy_q;
  logic [2:0]  burn_idx_q;
  logic [2:0]  blk_idx_q;
  logic [2:0]  chk_next_q;
  logic [3:0]  ref_crc_q;
  logic        ref_valid_q;
  logic [7:0]  rdata_q;
  logic        resp_valid_q;

  logic        w1_start;
  logic [7:0]  w1_base;
  logic [7:0]  w1_rd_addr;
  logic [7:0]  w1_rd_data;
  logic        w1_busy;
  logic        w1_done;
  logic [3:0]  w1_crc;
  logic        w2_start;
  logic [7:0]  w2_rd_addr;
  logic        w2_busy;
  logic        w2_done;
  logic [3:0]  w2_crc;

  logic        acc_mapped;
  logic        acc_writable;
  logic        acc_in_array;
  logic [7:0]  acc_value;
  logic        next_locked;
  logic        burn_accept;
  logic        err_set_otp;
  logic        err_set_arr;
  logic [7:0]  cur_lock_addr;

  function automatic logic [7:0] lock_addr(input logic [2:0] idx);
    logic [7:0] b;
    b = otp_crc_pkg::block_base(idx);
    lock_addr = {b[7:4], otp_crc_pkg::LOCK_LOW_NIBBLE};
  endfunction : lock_addr

  assign cur_lock_addr = lock_addr(blk_idx_q);
  assign next_locked   = mem_q[lock_addr(chk_next_q)][otp_crc_pkg::LOCK_POS];

  // Address decode for the host port.
  always_comb begin
    logic [7:0] a;
    a            = BUS_REQ.addr;
    acc_in_array = (a[7:5] == otp_crc_pkg::RW_PAGE_HI) || (a[7:4] >= otp_crc_pkg::FACTORY_FIRST_HI);
    acc_mapped   = acc_in_array || a == otp_crc_pkg::CTRL_OFS || a == otp_crc_pkg::BURN_OFS
                   || a == otp_crc_pkg::STAT_OFS;
    acc_writable = 1'b0;
    if (!acc_in_array) begin
      acc_writable = acc_mapped;
    end else if (a == otp_crc_pkg::DEV_LOCK_OFS) begin
      acc_writable = 1'b1;
    end else if (a[3:0] == otp_crc_pkg::LOCK_LOW_NIBBLE && a >= otp_crc_pkg::MOD_BASE) begin
      acc_writable = 1'b0;
    end else if (a[7:5] == otp_crc_pkg::RW_PAGE_HI) begin
      acc_writable = !init_q;
    end else if (a[7:4] >= otp_crc_pkg::USER_FIRST_HI) begin
      acc_writable = !init_q && !mem_q[{a[7:4], otp_crc_pkg::LOCK_LOW_NIBBLE}][otp_crc_pkg::LOCK_POS];
    end
    acc_value = 8'h00;
    if (a == otp_crc_pkg::CTRL_OFS) begin
      acc_value = {7'h00, init_q};
    end else if (a == otp_crc_pkg::BURN_OFS) begin
      acc_value = {burn_busy_q, 4'h0, burn_idx_q};
    end else if (a == otp_crc_pkg::STAT_OFS) begin
      acc_value = {5'h00, arr_err_q, otp_err_q, burn_busy_q};
    end else if (a == otp_crc_pkg::MOD_LOCK_OFS) begin
      acc_value = {mem_q[a][7], 3'h0, mem_q[a][3:0]};
    end else if (acc_in_array) begin
      acc_value = mem_q[a];
    end
  end

  assign burn_accept = BUS_REQ.wr && BUS_REQ.addr == otp_crc_pkg::BURN_OFS && !burn_busy_q
                       && BUS_REQ.wdata[2:0] < otp_crc_pkg::NUM_BLOCKS
                       && !mem_q[lock_addr(BUS_REQ.wdata[2:0])][otp_crc_pkg::LOCK_POS];

  // Host answer: reads return the location, accepted writes return the written byte, others what stands there.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rdata_q      <= otp_crc_pkg::RESET_BYTE;
      resp_valid_q <= 1'b0;
    end else begin
      resp_valid_q <= BUS_REQ.rd || BUS_REQ.wr;
      if (BUS_REQ.rd) begin
        rdata_q <= acc_value;
      end else if (BUS_REQ.wr) begin
        if (!acc_mapped) begin
          rdata_q <= 8'h00;
        end else if (!acc_writable) begin
          rdata_q <= acc_value;
        end else begin
          rdata_q <= BUS_REQ.wdata;
        end
      end
    end
  end

  // Register array: host writes plus the automatic lock byte at the end of a burn.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      for (int i = 0; i < 256; i++) begin
        mem_q[i] <= otp_crc_pkg::RESET_BYTE;
      end
    end else begin
      if (BUS_REQ.wr && acc_in_array && acc_writable) begin
        mem_q[BUS_REQ.addr] <= BUS_REQ.wdata;
      end
      if (state_q == ST_BURN && w1_done) begin
        mem_q[cur_lock_addr] <= {1'b1, blk_idx_q, w1_crc};
      end
    end
  end

  // The modifiable mirrors stay writable, so the burned image is kept apart for checking.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      for (int i = 0; i < 16; i++) begin
        mod_otp_q[i] <= otp_crc_pkg::RESET_BYTE;
      end
    end else if (state_q == ST_BURN && blk_idx_q == 3'h0 && w1_busy) begin
      mod_otp_q[w1_rd_addr[3:0]] <= mem_q[w1_rd_addr];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      init_q <= 1'b0;
    end else if (BUS_REQ.wr && BUS_REQ.addr == otp_crc_pkg::CTRL_OFS
                 && BUS_REQ.wdata[otp_crc_pkg::INIT_POS]) begin
      init_q <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      burn_pend_q <= 1'b0;
      burn_busy_q <= 1'b0;
      burn_idx_q  <= 3'h0;
    end else begin
      if (burn_accept) begin
        burn_pend_q <= 1'b1;
        burn_busy_q <= 1'b1;
        burn_idx_q  <= BUS_REQ.wdata[2:0];
      end else begin
        if (state_q == ST_IDLE && burn_pend_q) begin
          burn_pend_q <= 1'b0;
        end
        if (state_q == ST_BURN && w1_done) begin
          burn_busy_q <= 1'b0;
        end
      end
    end
  end

  // A burn request takes the walker first; otherwise burned blocks are checked in turn.
  assign w1_start   = (state_q == ST_IDLE) && (burn_pend_q || next_locked);
  assign w1_base    = otp_crc_pkg::block_base(burn_pend_q ? burn_idx_q : chk_next_q);
  assign w1_rd_data = (state_q == ST_CHECK && blk_idx_q == 3'h0) ? mod_otp_q[w1_rd_addr[3:0]]
                                                                 : mem_q[w1_rd_addr];

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_q    <= ST_IDLE;
      blk_idx_q  <= 3'h0;
      chk_next_q <= 3'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (burn_pend_q) begin
            blk_idx_q <= burn_idx_q;
            state_q   <= ST_BURN;
          end else begin
            if (next_locked) begin
              blk_idx_q <= chk_next_q;
              state_q   <= ST_CHECK;
            end
            chk_next_q <= (chk_next_q == otp_crc_pkg::NUM_BLOCKS - 3'h1) ? 3'h0 : chk_next_q + 3'h1;
          end
        end
        ST_BURN: begin
          if (w1_done) begin
            state_q <= ST_IDLE;
          end
        end
        ST_CHECK: begin
          if (w1_done) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  crc_byte_walker #(.CNT_W(6)) u_block_walk (
    .clk       (CORE_CLK),
    .srst      (SRST),
    .start     (w1_start),
    .base      (w1_base),
    .count     (otp_crc_pkg::BLOCK_DATA_BYTES),
    .skip_en   (1'b0),
    .skip_addr (8'h00),
    .rd_data   (w1_rd_data),
    .rd_addr   (w1_rd_addr),
    .busy      (w1_busy),
    .done      (w1_done),
    .crc       (w1_crc)
  );

  // The running array CRC only starts once init is complete.
  assign w2_start = init_q && !w2_busy;

  crc_byte_walker #(.CNT_W(6)) u_array_walk (
    .clk       (CORE_CLK),
    .srst      (SRST),
    .start     (w2_start),
    .base      (otp_crc_pkg::RW_BASE),
    .count     (otp_crc_pkg::ARRAY_BYTES),
    .skip_en   (1'b1),
    .skip_addr (otp_crc_pkg::DEV_LOCK_OFS),
    .rd_data   (mem_q[w2_rd_addr]),
    .rd_addr   (w2_rd_addr),
    .busy      (w2_busy),
    .done      (w2_done),
    .crc       (w2_crc)
  );

  // The first full pass after init is the reference; later passes must match it.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ref_crc_q   <= otp_crc_pkg::CRC_SEED;
      ref_valid_q <= 1'b0;
    end else if (w2_done && !ref_valid_q) begin
      ref_crc_q   <= w2_crc;
      ref_valid_q <= 1'b1;
    end
  end

  assign err_set_otp = state_q == ST_CHECK && w1_done
                       && w1_crc != mem_q[cur_lock_addr][otp_crc_pkg::CRC_MSB:0];
  assign err_set_arr = w2_done && ref_valid_q && w2_crc != ref_crc_q;

  // A new error in the clearing cycle wins, so no mismatch is ever lost.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      otp_err_q <= 1'b0;
      arr_err_q <= 1'b0;
    end else begin
      otp_err_q <= (otp_err_q && !(BUS_REQ.wr && BUS_REQ.addr == otp_crc_pkg::STAT_OFS
                   && BUS_REQ.wdata[otp_crc_pkg::OTP_ERR_POS])) || err_set_otp;
      arr_err_q <= (arr_err_q && !(BUS_REQ.wr && BUS_REQ.addr == otp_crc_pkg::STAT_OFS
                   && BUS_REQ.wdata[otp_crc_pkg::ARR_ERR_POS])) || err_set_arr;
    end
  end

  assign BUS_RDATA      = rdata_q;
  assign BUS_RESP_VALID = resp_valid_q;
  assign INIT_COMPLETE  = init_q;
  assign BURN_BUSY      = burn_busy_q;
  assign OTP_CRC_ERR    = otp_err_q;
  assign ARRAY_CRC_ERR  = arr_err_q;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  AST_BURN_WRITES_LOCK: assert property (
    (state_q == ST_BURN && w1_done) |=> mem_q[$past(cur_lock_addr)] == {1'b1, $past(blk_idx_q), $past(w1_crc)})
    else $error("burn did not write the lock byte");
  AST_LOCK_ONLY_BY_BURN: assert property (
    $rose(mem_q[otp_crc_pkg::MOD_LOCK_OFS][7]) |-> $past(state_q == ST_BURN && w1_done && blk_idx_q == 3'h0))
    else $error("lock bit set without a burn");
  AST_MOD_RESERVED_ZERO: assert property (
    (BUS_REQ.rd && BUS_REQ.addr == otp_crc_pkg::MOD_LOCK_OFS) |=> BUS_RESP_VALID && BUS_RDATA[6:4] == 3'h0)
    else $error("modifiable lock byte bits 6 to 4 not zero");
  AST_PREINIT_WRITE: assert property (
    (BUS_REQ.wr && !init_q && BUS_REQ.addr[7:4] == 4'h5 && BUS_REQ.addr[3:0] != 4'hF)
    |=> mem_q[$past(BUS_REQ.addr)] == $past(BUS_REQ.wdata))
    else $error("mirror write before init lost");
  AST_NO_ARRAY_CRC_BEFORE_INIT: assert property (
    !init_q |-> !w2_busy && !w2_done)
    else $error("array CRC ran before init");
  AST_UNMAPPED_READ: assert property (
    (BUS_REQ.rd && !acc_mapped) |=> BUS_RESP_VALID && BUS_RDATA == 8'h00)
    else $error("unmapped read not answered with zero");
  AST_UNMAPPED_WRITE: assert property (
    (BUS_REQ.wr && !acc_mapped) |=> BUS_RESP_VALID && BUS_RDATA == 8'h00 && $stable(init_q))
    else $error("unmapped write not answered with zero");
  AST_RO_WRITE_KEEPS: assert property (
    (BUS_REQ.wr && acc_in_array && !acc_writable && !(state_q == ST_BURN && w1_done))
    |=> BUS_RDATA == $past(acc_value) && mem_q[$past(BUS_REQ.addr)] == $past(acc_value))
    else $error("read-only write changed the register or answered wrongly");
  AST_CHECK_ERROR: assert property (
    err_set_otp |=> OTP_CRC_ERR ##1 (OTP_CRC_ERR || $past(BUS_REQ.wr)))
    else $error("block CRC mismatch not flagged");

  COV_BURN_DONE: cover property (state_q == ST_BURN && w1_done);
  COV_CHECK_FAIL: cover property (err_set_otp);
  COV_ARRAY_FAIL: cover property (err_set_arr);
endmodule : otp_block_lock_crc_check

/* File: verif/host_master_model.sv */
// Purpose: Host master model that issues one register read or write at a time.
// Assumes: Strobes are one cycle long and change only just after a rising edge.
// Notes:   Address and data are inverted between commands so stale values are never trusted.
module host_master_model (
  input  wire logic             clk,
  output otp_crc_pkg::bus_req_t req
);
  timeunit 1ns;
  timeprecision 100ps;

  initial req = '0;

  // The device never stalls, so the strobe stands for exactly one edge.
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    req <= '{wr: wr, rd: !wr, addr: addr, wdata: data};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask : access
endmodule : host_master_model

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the OTP lock, identifier and CRC block.
// Assumes: Answers arrive one cycle after every strobe, in issue order.
// Notes:   Expected answers are queued by the driver and checked by a monitor.
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  CORE_CLK = 1'b0;
  logic                  SRST     = 1'b1;
  otp_crc_pkg::bus_req_t bus_req;
  logic [7:0]            bus_rdata;
  logic                  resp_valid;
  logic                  init_complete;
  logic                  burn_busy;
  logic                  otp_err;
  logic                  arr_err;
  int                    fail_count  = 0;
  int                    comparisons = 0;
  logic [8:0]            exp_q[$];
  logic [8:0]            ent;
  logic [7:0]            mem[256];
  logic [7:0]            b;
  logic [7:0]            d;

  always #20 CORE_CLK = ~CORE_CLK;

  host_master_model u_host_master_model (
    .clk(CORE_CLK),
    .req(bus_req)
  );

  otp_block_lock_crc_check u_otp_block_lock_crc_check (
    .CORE_CLK      (CORE_CLK),
    .SRST          (SRST),
    .BUS_REQ       (bus_req),
    .BUS_RDATA     (bus_rdata),
    .BUS_RESP_VALID(resp_valid),
    .INIT_COMPLETE (init_complete),
    .BURN_BUSY     (burn_busy),
    .OTP_CRC_ERR   (otp_err),
    .ARRAY_CRC_ERR (arr_err)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // The top bit of a note says whether the answer data is compared at all.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({1'b1, e});
    u_host_master_model.access(1'b0, a, 8'h00);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] e, input logic c);
    exp_q.push_back({c, e});
    u_host_master_model.access(1'b1, a, v);
  endtask : wr

  // Reference remainder over the fifteen data bytes of a block, kept apart from the design.
  function automatic logic [3:0] crc_ref(input logic [7:0] base);
    logic [3:0] c;
    logic       fb;
    c = 4'h0;
    for (int a = 0; a < 15; a++) begin
      for (int k = 7; k >= 0; k--) begin
        fb = c[3] ^ mem[base + 8'(a)][k];
        c  = {c[2:0], 1'b0} ^ (fb ? 4'h9 : 4'h0);
      end
    end
    return c;
  endfunction : crc_ref

  always @(posedge CORE_CLK) begin
    if (resp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("answer count", 8'h01, 8'h00);
      end else begin
        ent = exp_q.pop_front();
        if (ent[8]) begin
          check("answer data", bus_rdata, ent[7:0]);
        end
      end
    end
  end

  initial begin
    repeat (20000) @(posedge CORE_CLK);
    fail_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(88949));
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
    end
    repeat (12) @(posedge CORE_CLK);
    SRST <= 1'b0;
    rd(8'h5F, 8'h00);
    rd(8'hEF, 8'h00);
    rd(8'hFF, 8'h00);
    rd(8'h30, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h10, 8'h5A, 8'h00, 1'b1);
    rd(8'h10, 8'h00);
    wr(8'h5F, 8'h8F, 8'h00, 1'b1);
    rd(8'h5F, 8'h00);
    wr(8'h40, 8'hA5, 8'hA5, 1'b1);
    mem[8'h40] = 8'hA5;
    rd(8'h40, 8'hA5);
    for (int idx = 0; idx < 7; idx++) begin
      b = (idx == 0) ? 8'h50 : 8'h90 + {4'(idx), 4'h0};
      if (idx == 0 || idx >= 5) begin
        for (int k = 0; k < 15; k++) begin
          d = 8'($urandom);
          wr(b + 8'(k), d, d, 1'b1);
          mem[b + 8'(k)] = d;
        end
      end
      wr(8'h31, {5'h00, 3'(idx)}, 8'h00, 1'b0);
      repeat (3) @(posedge CORE_CLK);
      check("burn busy", {7'h00, burn_busy}, 8'h01);
      for (int i = 0; i < 300 && burn_busy !== 1'b0; i++) begin
        @(posedge CORE_CLK);
      end
      check("burn done", {7'h00, burn_busy}, 8'h00);
      rd(b + 8'h0F, {1'b1, 3'(idx), crc_ref(b)});
    end
    wr(8'hE0, 8'h33, mem[8'hE0], 1'b1);
    rd(8'hE0, mem[8'hE0]);
    wr(8'h30, 8'h01, 8'h00, 1'b0);
    repeat (3) @(posedge CORE_CLK);
    check("init flag", {7'h00, init_complete}, 8'h01);
    wr(8'h4F, 8'h77, 8'h77, 1'b1);
    rd(8'h4F, 8'h77);
    // Once init is complete the mirrors other than 0x4F are frozen, so the write answers the old byte.
    wr(8'h50, 8'h11, mem[8'h50], 1'b1);
    rd(8'h50, mem[8'h50]);
    // A second burn of a locked block must be refused and leave the last index standing.
    wr(8'h31, 8'h00, 8'h00, 1'b0);
    repeat (3) @(posedge CORE_CLK);
    check("refused burn", {7'h00, burn_busy}, 8'h00);
    rd(8'h31, 8'h06);
    rd(8'h30, 8'h01);
    repeat (150) @(posedge CORE_CLK);
    check("array crc error", {7'h00, arr_err}, 8'h00);
    check("otp crc error", {7'h00, otp_err}, 8'h00);
    rd(8'h32, 8'h00);
    repeat (4) @(posedge CORE_CLK);
    check("pending answers", 8'(exp_q.size()), 8'h00);
    report_and_stop();
  end
endmodule : tb
